// File: core/afr_debounce.sv
/*
Two-flop synchroniser and debounce filter for a vector of pin inputs.
Assumes inputs are asynchronous to clk; ready rises once filters have settled after reset.
*/
`timescale 1ns/1ns
`default_nettype none
module afr_debounce #(
	parameter int W = 16,
	parameter int CYC = afr_pkg::DEB_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q,
	output logic ready
);
	import afr_pkg::*;
	localparam int CW = $clog2(CYC + 3);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] q;
		logic [W-1:0][CW-1:0] cnt;
		logic [CW-1:0] rcnt;
		logic ready;
	} afr_deb_t;
	afr_deb_t st_ff;
	afr_deb_t nxt_st;

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.s1 = d;
		nxt_st.s2 = st_ff.s1;
		if (st_ff.rcnt == CW'(CYC + 2))
			nxt_st.ready = 1'b1;
		else
			nxt_st.rcnt = st_ff.rcnt + 1'b1;
		// A level must hold unchanged for the whole window before it is accepted.
		for (int i = 0; i < W; i++)
		begin
			if (st_ff.s2[i] == st_ff.q[i])
				nxt_st.cnt[i] = '0;
			else if (st_ff.cnt[i] == CW'(CYC - 1))
			begin
				nxt_st.q[i] = st_ff.s2[i];
				nxt_st.cnt[i] = '0;
			end
			else
				nxt_st.cnt[i] = st_ff.cnt[i] + 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			st_ff <= '0;
		else if (ce)
			st_ff <= nxt_st;
	end

	assign q = st_ff.q;
	assign ready = st_ff.ready;
endmodule
`default_nettype wire

// File: core/afr_failover_ctrl.sv
/*
Route and indication control for an eight-path failover switcher with two standbys.
Assumes raw pins (alarms, supplies, buttons) are asynchronous and a simple register port.
*/
`timescale 1ns/1ns
`default_nettype none
module afr_failover_ctrl #(
	parameter int DEB_CYC = afr_pkg::DEB_CYC,
	parameter int STEP_CYC = afr_pkg::STEP_CYC,
	parameter int BLINK_CYC = afr_pkg::BLINK_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire afr_pkg::afr_bus_req_t bus,
	output logic [31:0] rdata,
	input wire afr_pkg::afr_pins_t pins,
	output logic [2*afr_pkg::NCH-1:0] route_sel,
	output logic [2*afr_pkg::NCH-1:0] chan_indicator,
	output logic supply_one_indicator,
	output logic supply_two_indicator,
	output logic [afr_pkg::NSB-1:0] restore_red,
	output logic [afr_pkg::NSB-1:0] restore_green,
	output logic [4:0] alarm_relay_output,
	output logic bootstrap_mode,
	output logic factory_default_done
);
	import afr_pkg::*;
	localparam afr_route_t SB_RT [NSB] = '{RT_SB1, RT_SB2};

	afr_state_t st_ff;
	afr_state_t nxt_st;
	logic [PIN_W-1:0] pins_raw;
	afr_pins_t pins_q;
	logic deb_ready;
	logic blink_tick;
	logic step_tick;
	logic [1:0] btn_rise;
	logic [NCH-1:0] al;
	logic [NSB-1:0] sb_al;
	logic [NSB-1:0][NCH-1:0] on_sb;
	logic [NSB-1:0] sb_occ;
	logic [NSB-1:0] used_alm;
	logic [NSB-1:0] used_clr;

	afr_debounce #(
		.W(PIN_W),
		.CYC(DEB_CYC)
	) u_deb (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.d(pins),
		.q(pins_raw),
		.ready(deb_ready)
	);

	afr_tick #(
		.CYC(BLINK_CYC)
	) u_blink (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.clr(1'b0),
		.tick(blink_tick)
	);

	// The step timer restarts on each press of button two so the first step is a full second.
	afr_tick #(
		.CYC(STEP_CYC)
	) u_step (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.clr(btn_rise[1]),
		.tick(step_tick)
	);

	assign pins_q = afr_pins_t'(pins_raw);
	assign al = pins_q.alarm_contact_input;
	assign sb_al = pins_q.standby_alarm;
	assign btn_rise = pins_q.button & ~st_ff.btn_prev;

	genvar gk;
	genvar gc;
	generate
		for (gk = 0; gk < NSB; gk++)
		begin : g_sb
			for (gc = 0; gc < NCH; gc++)
			begin : g_ch
				assign on_sb[gk][gc] = (st_ff.route[gc] == SB_RT[gk]);
			end
			assign sb_occ[gk] = |on_sb[gk];
			assign used_alm[gk] = |(on_sb[gk] & al);
			assign used_clr[gk] = |(on_sb[gk] & ~al);
		end
	endgenerate

	always_comb
	begin
		logic [NSB-1:0] occ;
		logic [NSB-1:0] rel;
		logic auto_eff;
		logic done;
		logic run;
		int s;
		nxt_st = st_ff;
		occ = sb_occ;
		rel = '0;
		auto_eff = 1'b0;
		done = 1'b0;
		run = st_ff.strap_done && !st_ff.boot;
		s = 0;
		if (blink_tick)
			nxt_st.blink = ~st_ff.blink;
		if (blink_tick && st_ff.fd_cnt != 5'h00)
			nxt_st.fd_cnt = st_ff.fd_cnt - 5'h01;

		if (bus.wr)
		begin
			case (bus.addr)
				REG_CTRL:
				begin
					nxt_st.cfg_auto = bus.wdata[NCH-1:0];
					nxt_st.cfg_sil = bus.wdata[CTRL_SIL_LSB +: NCH];
					if (bus.wdata[CTRL_GM_LSB +: 2] == GM_AUTO)
						nxt_st.gmode = GM_AUTO;
					else if (bus.wdata[CTRL_GM_LSB +: 2] == GM_MAN)
						nxt_st.gmode = GM_MAN;
					else
						nxt_st.gmode = GM_GUI;
				end
				REG_ALLOW:
					nxt_st.cfg_allow = bus.wdata[2*NCH-1:0];
				default:
					nxt_st.cfg_allow = st_ff.cfg_allow;
			endcase
		end

		// Buttons are sampled once the filters settle, standing in for a power-on strap.
		if (!st_ff.strap_done && deb_ready)
		begin
			nxt_st.strap_done = 1'b1;
			nxt_st.btn_prev = pins_q.button;
			if (pins_q.button == 2'b11)
				nxt_st.boot = 1'b1;
			else if (pins_q.button[0])
			begin
				nxt_st.fdef = 1'b1;
				nxt_st.fd_cnt = FD_FLASH_TOGGLES;
				nxt_st.cfg_auto = RST_AUTO;
				nxt_st.cfg_sil = RST_SIL;
				nxt_st.cfg_allow = RST_ALLOW;
				nxt_st.gmode = GM_GUI;
			end
		end

		if (run)
		begin
			nxt_st.btn_prev = pins_q.button;
			rel[0] = btn_rise[0];
			// A short press of button two restores; a long hold steps the global choice.
			if (pins_q.button[1])
			begin
				if (step_tick)
				begin
					if (st_ff.hold == HP_NONE || st_ff.hold == HP_GREEN)
						nxt_st.hold = HP_ORANGE;
					else
						nxt_st.hold = afr_hold_t'(st_ff.hold + 2'b01);
				end
			end
			else if (st_ff.btn_prev[1])
			begin
				nxt_st.hold = HP_NONE;
				case (st_ff.hold)
					HP_NONE: rel[1] = 1'b1;
					HP_ORANGE: nxt_st.gmode = GM_AUTO;
					HP_RED: nxt_st.gmode = GM_MAN;
					default: nxt_st.gmode = GM_GUI;
				endcase
			end
		end

		// One two-bit route per path drives every relay of that path together.
		for (int c = 0; c < NCH; c++)
		begin
			case (st_ff.gmode)
				GM_AUTO: auto_eff = 1'b1;
				GM_MAN: auto_eff = 1'b0;
				default: auto_eff = st_ff.cfg_auto[c];
			endcase
			done = 1'b0;
			if (st_ff.boot)
				nxt_st.route[c] = RT_THRU;
			else if (!run)
				nxt_st.route[c] = st_ff.route[c];
			else if (st_ff.route[c] == RT_THRU || st_ff.route[c] == RT_SIL)
			begin
				if (al[c])
				begin
					// Paths are scanned in order so two alarms never share a standby.
					for (int k = 0; k < NSB; k++)
					begin
						if (!done && st_ff.cfg_allow[2*c+k] && !occ[k] && !sb_al[k])
						begin
							nxt_st.route[c] = SB_RT[k];
							occ[k] = 1'b1;
							done = 1'b1;
						end
					end
					if (!done)
						nxt_st.route[c] = st_ff.cfg_sil[c] ? RT_SIL : RT_THRU;
				end
				else
					nxt_st.route[c] = RT_THRU;
			end
			else
			begin
				s = (st_ff.route[c] == RT_SB2) ? 1 : 0;
				// A cleared path stays on standby until auto mode or its button releases it.
				if (!al[c] && (auto_eff || rel[s]))
					nxt_st.route[c] = RT_THRU;
			end

			case (st_ff.route[c])
				RT_SB1: nxt_st.ch_ind[2*c +: 2] = 2'b01;
				RT_SB2: nxt_st.ch_ind[2*c +: 2] = 2'b10;
				RT_SIL: nxt_st.ch_ind[2*c +: 2] = {2{st_ff.blink}};
				default: nxt_st.ch_ind[2*c +: 2] = al[c] ? {2{st_ff.blink}} : 2'b00;
			endcase
		end

		for (int p = 0; p < 2; p++)
		begin
			if (st_ff.fd_cnt != 5'h00)
				nxt_st.sup_ind[p] = st_ff.blink;
			else if (!pins_q.supply_present[p])
				nxt_st.sup_ind[p] = 1'b0;
			else
				nxt_st.sup_ind[p] = pins_q.supply_low[p] ? st_ff.blink : 1'b1;
		end

		for (int k = 0; k < NSB; k++)
		begin
			if (st_ff.hold != HP_NONE)
			begin
				nxt_st.red[k] = (st_ff.hold != HP_GREEN);
				nxt_st.grn[k] = (st_ff.hold != HP_RED);
			end
			else if (sb_al[k])
			begin
				nxt_st.red[k] = 1'b1;
				nxt_st.grn[k] = 1'b0;
			end
			else if (used_alm[k] || used_clr[k])
			begin
				// Orange steady for an alarmed user, flashing once it waits on manual restore.
				nxt_st.red[k] = used_alm[k] | st_ff.blink;
				nxt_st.grn[k] = used_alm[k] | st_ff.blink;
			end
			else
			begin
				nxt_st.red[k] = 1'b0;
				nxt_st.grn[k] = 1'b1;
			end
		end

		nxt_st.relay[0] = ~pins_q.supply_present[0] | pins_q.supply_low[0];
		nxt_st.relay[1] = ~pins_q.supply_present[1] | pins_q.supply_low[1];
		nxt_st.relay[3:2] = sb_occ;
		nxt_st.relay[4] = (|al) | (|sb_al) | (|sb_occ) | (|nxt_st.relay[1:0]);

		nxt_st.rdata = 32'h0000_0000;
		if (bus.rd)
		begin
			case (bus.addr)
				REG_CTRL: nxt_st.rdata = {14'h0000, st_ff.gmode, st_ff.cfg_sil, st_ff.cfg_auto};
				REG_ALLOW: nxt_st.rdata = {16'h0000, st_ff.cfg_allow};
				REG_STATUS: nxt_st.rdata = {12'h000, st_ff.fdef, st_ff.boot, sb_occ, st_ff.route};
				REG_INPUTS: nxt_st.rdata = {16'h0000, pins_q};
				default: nxt_st.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_ff <= '0;
			st_ff.cfg_auto <= RST_AUTO;
			st_ff.cfg_sil <= RST_SIL;
			st_ff.cfg_allow <= RST_ALLOW;
		end
		else if (ce)
			st_ff <= nxt_st;
	end

	// Path count and standby count are fixed at eight and two by the package.
	assign rdata = st_ff.rdata;
	assign route_sel = st_ff.route;
	assign chan_indicator = st_ff.ch_ind;
	assign supply_one_indicator = st_ff.sup_ind[0];
	assign supply_two_indicator = st_ff.sup_ind[1];
	assign restore_red = st_ff.red;
	assign restore_green = st_ff.grn;
	assign alarm_relay_output = st_ff.relay;
	assign bootstrap_mode = st_ff.boot;
	assign factory_default_done = st_ff.fdef;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst || !ce);

	a_boot_all_thru: assert property (st_ff.boot |-> route_sel == '0)
		else $error("bootstrap mode with a path off through");
	a_sb_single_user: assert property ($countones(on_sb[0]) <= 1 && $countones(on_sb[1]) <= 1)
		else $error("standby shared by two paths");
	a_alarm_takes_sb: assert property ((ce && st_ff.strap_done && !st_ff.boot && st_ff.route[0] == RT_THRU
		&& al[0] && st_ff.cfg_allow[0] && !sb_occ[0] && !sb_al[0]) |=> route_sel[1:0] == RT_SB1)
		else $error("alarmed path did not take free standby one");
	a_fallback_silence: assert property ((ce && st_ff.strap_done && !st_ff.boot && st_ff.route[5] == RT_THRU
		&& al[5] && (st_ff.cfg_allow[11:10] & ~sb_occ & ~sb_al) == 2'b00 && st_ff.cfg_sil[5])
		|=> route_sel[11:10] == RT_SIL)
		else $error("fallback to silence not taken");
	a_auto_return: assert property ((ce && st_ff.strap_done && !st_ff.boot && st_ff.route[7] == RT_SB1
		&& !al[7] && st_ff.gmode == GM_AUTO) |=> route_sel[15:14] == RT_THRU)
		else $error("global auto did not restore path");
	a_manual_holds: assert property ((ce && st_ff.strap_done && st_ff.route[3] == RT_SB1 && !al[3]
		&& st_ff.gmode != GM_AUTO && !st_ff.cfg_auto[3] && !btn_rise[0]) |=> route_sel[7:6] == RT_SB1)
		else $error("manual path left standby without restore");
	a_chan_ind_sb2: assert property ((ce && st_ff.route[1] == RT_SB2) |=> chan_indicator[3:2] == 2'b10)
		else $error("standby two indication wrong");
	a_chan_flash_pair: assert property ((ce && st_ff.route[5] == RT_SIL)
		|=> chan_indicator[11] == chan_indicator[10])
		else $error("silence indication not paired");
	a_supply_dark: assert property ((ce && !pins_q.supply_present[0] && st_ff.fd_cnt == 5'h00)
		|=> !supply_one_indicator)
		else $error("supply indicator lit with no supply");
	a_relay_sb_act: assert property (ce |=> alarm_relay_output[3:2] == $past(sb_occ))
		else $error("standby relay does not follow occupancy");
	a_hold_orange: assert property ((ce && st_ff.hold == HP_ORANGE)
		|=> restore_red == 2'b11 && restore_green == 2'b11)
		else $error("hold orange not shown on both buttons");
	a_button_red: assert property ((ce && st_ff.hold == HP_NONE && sb_al[0])
		|=> restore_red[0] && !restore_green[0])
		else $error("alarmed standby not shown red");

	c_take_sb1: cover property (st_ff.route[0] == RT_THRU ##1 st_ff.route[0] == RT_SB1);
	c_take_sb2: cover property (st_ff.route[1] == RT_THRU ##1 st_ff.route[1] == RT_SB2);
	c_silence: cover property (st_ff.route[2] == RT_SIL);
	c_hold_red: cover property (st_ff.hold == HP_RED && !pins_q.button[1]);
endmodule
`default_nettype wire

// File: core/afr_pkg.sv
/*
Constants, types and carriers shared by the audio failover route control block.
Assumes a single 125 MHz clock and a synchronous active-high reset.
*/
// Summary of operation
// - Up to eight main paths and exactly two standby paths in either application.
// - Each main path watches its alarm input and routes through, standby, or silence.
// - An alarmed path takes a free standby first, else through or silence.
// - Per path, alarm clear returns to through automatically or waits for manual restore.
// - Restore one returns cleared paths from standby one, restore two from standby two.
// - Each path may be tied to chosen standbys, giving two four-to-one groups.
// - One route selection per path switches analogue, digital and serial together.
// - Through is the de-energised route, so power loss passes all paths straight.
// - Supply indicator steady when valid, dark when absent, flashing when voltage low.
// - Path indicators: both dark through, first standby one, second standby two.
// - Both path indicators flash on silence, or through while alarmed.
// - Restore light green when its standby is free and clear, red when alarmed.
// - Restore light orange for alarmed user, flashing orange when held by manual mode.
// - Holding restore two cycles orange, red, green; release selects shown setting.
// - Orange forces auto restore, red forces manual, green uses per-path setting.
// - Restore one held through reset restores all configuration to factory defaults.
// - After a factory default restore both supply indicators flash to confirm.
// - Both restore buttons held through reset enter bootstrap mode instead.
// - Relays for supply one fail, supply two fail, standby active, summary alarm.
package afr_pkg;
	localparam int NCH = 8;
	localparam int NSB = 2;
	localparam int CLK_KHZ = 125000;
	localparam int DEB_MS = 20;
	localparam int STEP_MS = 1000;
	localparam int BLINK_HALF_MS = 250;
	localparam int DEB_CYC = DEB_MS * CLK_KHZ;
	localparam int STEP_CYC = STEP_MS * CLK_KHZ;
	localparam int BLINK_CYC = BLINK_HALF_MS * CLK_KHZ;
	localparam logic [4:0] FD_FLASH_TOGGLES = 5'h0c;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ALLOW = 4'h1;
	localparam logic [3:0] REG_STATUS = 4'h2;
	localparam logic [3:0] REG_INPUTS = 4'h3;
	localparam int CTRL_SIL_LSB = 8;
	localparam int CTRL_GM_LSB = 16;
	localparam logic [NCH-1:0] RST_AUTO = 8'hff;
	localparam logic [NCH-1:0] RST_SIL = 8'h00;
	localparam logic [2*NCH-1:0] RST_ALLOW = 16'hffff;
	typedef enum logic [1:0] {RT_THRU = 2'b00, RT_SB1 = 2'b01, RT_SB2 = 2'b10, RT_SIL = 2'b11} afr_route_t;
	typedef enum logic [1:0] {GM_GUI = 2'b00, GM_AUTO = 2'b01, GM_MAN = 2'b10} afr_gmode_t;
	typedef enum logic [1:0] {HP_NONE = 2'b00, HP_ORANGE = 2'b01, HP_RED = 2'b10, HP_GREEN = 2'b11} afr_hold_t;
	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} afr_bus_req_t;
	typedef struct packed {
		logic [1:0] button;
		logic [1:0] supply_low;
		logic [1:0] supply_present;
		logic [NSB-1:0] standby_alarm;
		logic [NCH-1:0] alarm_contact_input;
	} afr_pins_t;
	localparam int PIN_W = $bits(afr_pins_t);
	typedef struct packed {
		afr_route_t [NCH-1:0] route;
		logic [NCH-1:0] cfg_auto;
		logic [NCH-1:0] cfg_sil;
		logic [2*NCH-1:0] cfg_allow;
		afr_gmode_t gmode;
		afr_hold_t hold;
		logic [1:0] btn_prev;
		logic strap_done;
		logic boot;
		logic fdef;
		logic blink;
		logic [4:0] fd_cnt;
		logic [2*NCH-1:0] ch_ind;
		logic [1:0] sup_ind;
		logic [NSB-1:0] red;
		logic [NSB-1:0] grn;
		logic [4:0] relay;
		logic [31:0] rdata;
	} afr_state_t;
endpackage

// File: core/afr_tick.sv
/*
Periodic one-cycle tick generator with a synchronous restart.
Assumes clr comes from logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module afr_tick #(
	parameter int CYC = afr_pkg::BLINK_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic clr,
	output logic tick
);
	import afr_pkg::*;
	localparam int CW = $clog2(CYC + 1);
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic tick;
	} afr_tick_t;
	afr_tick_t st_ff;
	afr_tick_t nxt_st;

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.tick = 1'b0;
		if (clr)
			nxt_st.cnt = '0;
		else if (st_ff.cnt == CW'(CYC - 1))
		begin
			nxt_st.cnt = '0;
			nxt_st.tick = 1'b1;
		end
		else
			nxt_st.cnt = st_ff.cnt + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			st_ff <= '0;
		else if (ce)
			st_ff <= nxt_st;
	end

	assign tick = st_ff.tick;
endmodule
`default_nettype wire

// File: verif/afr_field_model.sv
/*
Field-side model: path alarm contacts, standby alarms, supplies and the operator's restore buttons.
Assumes the bench calls its tasks one at a time; every change chatters for one cycle before it holds.
*/
`timescale 1ns/1ns
`default_nettype none
module afr_field_model (
	input wire logic clk,
	output var afr_pkg::afr_pins_t pins
);
	import afr_pkg::*;
	initial pins = '{button: 2'b00, supply_low: 2'b00, supply_present: 2'b11, standby_alarm: 2'b00,
		alarm_contact_input: 8'h00};
	// Real contacts bounce, so each change shows the new level, one cycle of the old, then the new.
	task automatic chatter(input afr_pins_t nv);
		afr_pins_t old;
		old = pins;
		@(posedge clk);
		pins <= nv;
		@(posedge clk);
		pins <= old;
		@(posedge clk);
		pins <= nv;
		@(posedge clk);
	endtask
	task automatic set_alarm(input int c, input logic v);
		afr_pins_t n;
		n = pins;
		n.alarm_contact_input[c] = v;
		chatter(n);
	endtask
	task automatic set_sb_alarm(input int s, input logic v);
		afr_pins_t n;
		n = pins;
		n.standby_alarm[s] = v;
		chatter(n);
	endtask
	task automatic set_supply(input logic [1:0] present, input logic [1:0] low);
		afr_pins_t n;
		n = pins;
		n.supply_present = present;
		n.supply_low = low;
		chatter(n);
	endtask
	// The operator presses, holds or releases the restore buttons, also across a reset.
	task automatic set_buttons(input logic [1:0] b);
		afr_pins_t n;
		n = pins;
		n.button = b;
		chatter(n);
	endtask
endmodule
`default_nettype wire

// File: verif/tb_top.sv
/*
Self-checking bench for the failover route control block.
Assumes the field model drives every pin and the shortened debounce, step and blink counts below.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import afr_pkg::*;
	localparam int DC = 4;
	localparam int SC = 20;
	localparam int BC = 3;
	logic clk = 1'b0;
	logic rst = 1'b1;
	afr_bus_req_t bus = '0;
	logic [31:0] rdata;
	afr_pins_t pins;
	logic [15:0] route_sel;
	logic [15:0] chan_indicator;
	logic sup1, sup2, boot, fdd;
	logic [1:0] rred, rgrn;
	logic [4:0] relay;
	int failures = 0;
	int check_count = 0;
	logic [31:0] rv, got;
	logic ce = 1'b1;
	always #4 clk = ~clk;
	afr_failover_ctrl #(.DEB_CYC(DC), .STEP_CYC(SC), .BLINK_CYC(BC)) dut (
		.clk(clk), .rst(rst), .ce(ce), .bus(bus), .rdata(rdata), .pins(pins),
		.route_sel(route_sel), .chan_indicator(chan_indicator), .supply_one_indicator(sup1),
		.supply_two_indicator(sup2), .restore_red(rred), .restore_green(rgrn),
		.alarm_relay_output(relay), .bootstrap_mode(boot), .factory_default_done(fdd));
	afr_field_model fm (.clk(clk), .pins(pins));
	task automatic close_out;
		$display("mismatches %0d comparisons %0d", failures, check_count);
		if (failures == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			$display("ERROR %s expected %h seen %h", name, exp, seen);
			failures++;
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask
	function automatic logic [31:0] ctrl_exp(input logic [31:0] d);
		return {14'h0, (d[17:16] == 2'b11) ? 2'b00 : d[17:16], d[15:0]};
	endfunction
	// Index 0-7 route, 8-15 path lamps, 16 supply lamps, 17-18 restore light {red, green}.
	function automatic logic [1:0] probe(input int k);
		if (k < 8)
			return route_sel[2*k +: 2];
		if (k < 16)
			return chan_indicator[2*(k-8) +: 2];
		if (k == 16)
			return {sup2, sup1};
		return {rred[k-17], rgrn[k-17]};
	endfunction
	task automatic settle;
		repeat (DC + 8) @(posedge clk);
		#1;
	endtask
	task automatic wait_val(input int k, input logic [1:0] e, input string name);
		int n;
		n = 0;
		while (probe(k) !== e && n < 60)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		check(name, {30'h0, probe(k)}, {30'h0, e});
	endtask
	task automatic flashes(input int k, input string name);
		logic [3:0] seen;
		seen = '0;
		repeat (30)
		begin
			@(posedge clk);
			#1;
			seen[probe(k)] = 1'b1;
		end
		check(name, {28'h0, seen & 4'h9}, 32'h9);
	endtask
	task automatic press(input logic [1:0] b);
		fm.set_buttons(b);
		repeat (DC + 4) @(posedge clk);
		fm.set_buttons(2'b00);
		settle();
	endtask
	task automatic hold_until(input logic [3:0] e, input string name);
		int n;
		n = 0;
		fm.set_buttons(2'b10);
		while ({rred, rgrn} !== e && n < 200)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		check(name, {28'h0, rred, rgrn}, {28'h0, e});
		fm.set_buttons(2'b00);
		settle();
	endtask
	// Buttons go down before reset and stay down until after the strap sample.
	task automatic do_reset(input logic [1:0] b);
		fm.set_buttons(b);
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (DC + 6) @(posedge clk);
		fm.set_buttons(2'b00);
	endtask
	initial
	begin
		repeat (100000) @(posedge clk);
		failures++;
		close_out();
	end
	initial
	begin
		rv = $urandom(32'h61346e81);
		do_reset(2'b00);
		settle();
		check("route_sel", {16'h0, route_sel}, 32'h0);
		rd(REG_CTRL, got); check("ctrl", got, 32'hff);
		@(posedge clk);
		#1;
		check("rdata one cycle", rdata, 32'h0);
		rd(REG_ALLOW, got); check("allow", got, 32'hffff);
		rd(4'h9, got); check("unmapped", got, 32'h0);
		wr(REG_CTRL, 32'h20ff);
		fm.set_alarm(0, 1'b1); wait_val(0, RT_SB1, "route0");
		wait_val(8, 2'b01, "lamps0");
		wait_val(17, 2'b11, "restore1 orange");
		fm.set_alarm(1, 1'b1); wait_val(1, RT_SB2, "route1");
		wait_val(9, 2'b10, "lamps1");
		fm.set_alarm(2, 1'b1); settle(); wait_val(2, RT_THRU, "route2");
		flashes(10, "lamps2 flash");
		fm.set_alarm(5, 1'b1); wait_val(5, RT_SIL, "route5");
		flashes(13, "lamps5 flash");
		check("relays", {27'h0, relay}, 32'h1c);
		rd(REG_STATUS, got); check("status", got, 32'h30c09);
		wr(REG_STATUS, 32'h0);
		rd(REG_STATUS, got); check("status ro", got, 32'h30c09);
		fm.set_alarm(5, 1'b0); wait_val(5, RT_THRU, "route5 clear");
		fm.set_alarm(2, 1'b0);
		fm.set_alarm(0, 1'b0); wait_val(0, RT_THRU, "route0 clear");
		fm.set_alarm(1, 1'b0); wait_val(1, RT_THRU, "route1 clear");
		wait_val(17, 2'b01, "restore1 green");
		fm.set_sb_alarm(0, 1'b1); wait_val(17, 2'b10, "restore1 red");
		fm.set_alarm(0, 1'b1); wait_val(0, RT_SB2, "route0 skip");
		fm.set_alarm(0, 1'b0); fm.set_sb_alarm(0, 1'b0);
		wr(REG_ALLOW, 32'hefff);
		fm.set_alarm(6, 1'b1); wait_val(6, RT_SB2, "route6 tied");
		fm.set_alarm(6, 1'b0); wait_val(6, RT_THRU, "route6 clear");
		wr(REG_ALLOW, 32'hffff);
		wr(REG_CTRL, 32'h0);
		fm.set_alarm(3, 1'b1); wait_val(3, RT_SB1, "route3");
		fm.set_alarm(4, 1'b1); wait_val(4, RT_SB2, "route4");
		fm.set_alarm(3, 1'b0); fm.set_alarm(4, 1'b0); settle();
		wait_val(3, RT_SB1, "route3 held");
		flashes(17, "restore1 flash");
		press(2'b10); wait_val(4, RT_THRU, "restore two");
		wait_val(3, RT_SB1, "route3 kept");
		press(2'b01); wait_val(3, RT_THRU, "restore one");
		hold_until(4'b1100, "hold red");
		rd(REG_CTRL, got); check("global manual", got, 32'h20000);
		hold_until(4'b1111, "hold orange");
		rd(REG_CTRL, got); check("global auto", got, 32'h10000);
		fm.set_alarm(7, 1'b1); wait_val(7, RT_SB1, "route7");
		fm.set_alarm(7, 1'b0); wait_val(7, RT_THRU, "route7 forced auto");
		// With the enable low nothing may move, not even the input filters.
		ce <= 1'b0;
		fm.set_alarm(7, 1'b1); settle();
		check("ce freeze", {16'h0, route_sel}, 32'h0);
		ce <= 1'b1;
		wait_val(7, RT_SB1, "route7 after freeze");
		fm.set_alarm(7, 1'b0); wait_val(7, RT_THRU, "route7 freeze clear");
		repeat (8)
		begin
			rv = $urandom;
			wr(REG_CTRL, rv);
			rd(REG_CTRL, got); check("ctrl random", got, ctrl_exp(rv));
		end
		fm.set_supply(2'b00, 2'b00); wait_val(16, 2'b00, "supply dark");
		check("supply relays", {30'h0, relay[1:0]}, 32'h3);
		fm.set_supply(2'b11, 2'b11); flashes(16, "supply low flash");
		fm.set_supply(2'b11, 2'b00); settle(); wait_val(16, 2'b11, "supply steady");
		do_reset(2'b01);
		flashes(16, "defaults flash");
		check("defaults done", {31'h0, fdd}, 32'h1);
		rd(REG_CTRL, got); check("defaults ctrl", got, 32'hff);
		do_reset(2'b11);
		settle();
		check("bootstrap", {31'h0, boot}, 32'h1);
		fm.set_alarm(0, 1'b1); settle(); wait_val(0, RT_THRU, "boot route");
		close_out();
	end
endmodule
`default_nettype wire
